//--- design/sbl_ctrl.sv
// host controller that drives an async 512k x 16 sram over its pins
`timescale 1ns/10ps
module sbl_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire sbl_pkg::sbl_req_s req,
	input wire logic req_valid,
	output logic req_ready,
	output logic [sbl_pkg::DATA_W-1:0] rsp_rdata,
	output logic rsp_valid,
	output logic power_ready,
	output logic [sbl_pkg::ADDR_W-1:0] mem_addr,
	output sbl_pkg::sbl_ctl_s mem_ctl,
	input wire logic [sbl_pkg::DATA_W-1:0] mem_dq_in,
	output logic [sbl_pkg::DATA_W-1:0] mem_dq_out,
	output logic mem_dq_oe
);
	sbl_pkg::sbl_state_e state_ff, nxt_state;
	logic [16:0] pwr_cnt_ff, nxt_pwr_cnt;
	logic [3:0] cnt_ff, nxt_cnt;
	sbl_pkg::sbl_req_s cur_ff, nxt_cur;
	logic [sbl_pkg::DATA_W-1:0] rdata_ff, nxt_rdata;
	logic rvalid_ff, nxt_rvalid;
	logic [sbl_pkg::DATA_W-1:0] dq_s1_ff, dq_s2_ff, dq_s3_ff;
	sbl_pkg::sbl_ctl_s ctl_ff, nxt_ctl;
	logic oe_ff, nxt_oe;
	logic [10:0] up_cnt_ff;
	// read data sampled from pins: 3-stage, take once stages 2 and 3 agree
	wire dq_stable = (dq_s2_ff == dq_s3_ff);
	wire cnt_done = (cnt_ff == 4'h0);
	wire pwr_done = (pwr_cnt_ff == 17'h00000);
	wire any_lane = ~&req.lane_n;
	wire idle = (state_ff == sbl_pkg::SBL_IDLE);
	wire take = idle & req_valid & any_lane;
	// drop requests with no lane selected: nothing would happen on the pins
	assign req_ready = idle;
	assign power_ready = ~(state_ff == sbl_pkg::SBL_POWER);
	assign rsp_rdata = rdata_ff;
	assign rsp_valid = rvalid_ff;
	assign mem_addr = cur_ff.addr;
	assign mem_ctl = ctl_ff;
	assign mem_dq_out = cur_ff.wdata;
	assign mem_dq_oe = oe_ff;
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_cur = cur_ff;
		nxt_rdata = rdata_ff;
		nxt_rvalid = 1'b0;
		nxt_ctl = ctl_ff;
		nxt_oe = oe_ff;
		nxt_pwr_cnt = pwr_done ? pwr_cnt_ff : pwr_cnt_ff - 17'h00001;
		case (state_ff)
			sbl_pkg::SBL_POWER:
			begin
				nxt_ctl = sbl_pkg::CTL_IDLE;
				if (pwr_done)
					nxt_state = sbl_pkg::SBL_IDLE;
			end
			sbl_pkg::SBL_IDLE:
			begin
				nxt_ctl = sbl_pkg::CTL_IDLE;
				nxt_oe = 1'b0;
				if (take)
				begin
					nxt_cur = req;
					nxt_cnt = sbl_pkg::SETUP_CYC - 4'h1;
					// address settles with select still high before the strobe falls
					nxt_state = req.write ? sbl_pkg::SBL_WR_SETUP : sbl_pkg::SBL_RD_SETUP;
				end
			end
			sbl_pkg::SBL_RD_SETUP:
			begin
				nxt_ctl = '{1'b0, 1'b0, 1'b1, cur_ff.lane_n[0], cur_ff.lane_n[1]};
				nxt_oe = 1'b0;
				nxt_cnt = sbl_pkg::RD_ACCESS_CYC + 4'h2;
				nxt_state = sbl_pkg::SBL_RD_WAIT;
			end
			sbl_pkg::SBL_RD_WAIT:
			begin
				nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 4'h1;
				if (cnt_done && dq_stable)
				begin
					nxt_rdata[7:0] = cur_ff.lane_n[0] ? 8'h00 : dq_s3_ff[7:0];
					nxt_rdata[15:8] = cur_ff.lane_n[1] ? 8'h00 : dq_s3_ff[15:8];
					nxt_rvalid = 1'b1;
					nxt_ctl = sbl_pkg::CTL_IDLE;
					// let the device float before we may drive again
					nxt_cnt = sbl_pkg::RELEASE_CYC;
					nxt_state = sbl_pkg::SBL_RELEASE;
				end
			end
			sbl_pkg::SBL_WR_SETUP:
			begin
				// oe stays high so device never fights our data
				nxt_ctl = '{1'b0, 1'b1, 1'b1, cur_ff.lane_n[0], cur_ff.lane_n[1]};
				nxt_oe = 1'b1;
				nxt_cnt = sbl_pkg::WR_PULSE_CYC - 4'h1;
				nxt_state = sbl_pkg::SBL_WR_PULSE;
			end
			sbl_pkg::SBL_WR_PULSE:
			begin
				nxt_ctl.write_strobe_n = 1'b0;
				nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 4'h1;
				if (cnt_done && !ctl_ff.write_strobe_n)
				begin
					nxt_ctl.write_strobe_n = 1'b1;
					nxt_state = sbl_pkg::SBL_WR_HOLD;
				end
			end
			sbl_pkg::SBL_WR_HOLD:
			begin
				// data and select held one cycle past strobe rise
				nxt_ctl = sbl_pkg::CTL_IDLE;
				nxt_oe = 1'b0;
				nxt_state = sbl_pkg::SBL_IDLE;
			end
			sbl_pkg::SBL_RELEASE:
			begin
				nxt_cnt = cnt_done ? cnt_ff : cnt_ff - 4'h1;
				if (cnt_done)
					nxt_state = sbl_pkg::SBL_IDLE;
			end
			default:
			begin
				nxt_ctl = sbl_pkg::CTL_IDLE;
				nxt_oe = 1'b0;
				nxt_state = sbl_pkg::SBL_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk)
	begin
		dq_s1_ff <= mem_dq_in;
		dq_s2_ff <= dq_s1_ff;
		dq_s3_ff <= dq_s2_ff;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_ff <= sbl_pkg::SBL_POWER;
			pwr_cnt_ff <= 17'(sbl_pkg::POWER_WAIT_CYC);
			cnt_ff <= 4'h0;
			cur_ff <= '0;
			rdata_ff <= 16'h0000;
			rvalid_ff <= 1'b0;
			ctl_ff <= sbl_pkg::CTL_IDLE;
			oe_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			pwr_cnt_ff <= nxt_pwr_cnt;
			cnt_ff <= nxt_cnt;
			cur_ff <= nxt_cur;
			rdata_ff <= nxt_rdata;
			rvalid_ff <= nxt_rvalid;
			ctl_ff <= nxt_ctl;
			oe_ff <= nxt_oe;
		end
	end
	// cycles since reset, saturating; only the power-wait check reads it,
	// so the wait is watched by a counter that is independent of the state machine
	always_ff @(posedge clk)
	begin
		if (rst)
			up_cnt_ff <= 11'h000;
		else if (!(&up_cnt_ff))
			up_cnt_ff <= up_cnt_ff + 11'h001;
	end
	power_count_a: assert property (@(posedge clk) disable iff (rst)
		!mem_ctl.chip_select_n |-> up_cnt_ff >= 11'(sbl_pkg::POWER_WAIT_CYC))
		else $error("select before power wait elapsed");
	addr_hold_a: assert property (@(posedge clk) disable iff (rst)
		!mem_ctl.chip_select_n |-> $stable(mem_addr))
		else $error("address moved while selected");
	lane_hold_a: assert property (@(posedge clk) disable iff (rst)
		!mem_ctl.write_strobe_n |-> $stable(mem_ctl.low_byte_lane_select_n)
		&& $stable(mem_ctl.high_byte_lane_select_n))
		else $error("lane select moved during write pulse");
	no_read_drive_a: assert property (@(posedge clk) disable iff (rst)
		!mem_ctl.output_enable_n |-> !mem_dq_oe)
		else $error("data driven while sram output enabled");
	write_overlap_a: assert property (@(posedge clk) disable iff (rst)
		!mem_ctl.write_strobe_n |-> !mem_ctl.chip_select_n && mem_dq_oe
		&& !(mem_ctl.low_byte_lane_select_n && mem_ctl.high_byte_lane_select_n))
		else $error("write strobe without select, lane or data");
	pulse_width_a: assert property (@(posedge clk) disable iff (rst)
		$fell(mem_ctl.write_strobe_n) |-> !mem_ctl.write_strobe_n[*1] ##1 mem_ctl.write_strobe_n)
		else $error("write pulse width wrong");
	data_hold_a: assert property (@(posedge clk) disable iff (rst)
		$rose(mem_ctl.write_strobe_n) |-> mem_dq_oe && $stable(mem_dq_out)
		&& !mem_ctl.chip_select_n)
		else $error("write data not held at strobe rise");
	power_wait_a: assert property (@(posedge clk) disable iff (rst)
		(state_ff == sbl_pkg::SBL_POWER) |-> mem_ctl.chip_select_n)
		else $error("access before power wait");
	idle_release_a: assert property (@(posedge clk) disable iff (rst)
		mem_ctl.chip_select_n |-> mem_ctl.write_strobe_n && mem_ctl.output_enable_n)
		else $error("strobes active while deselected");
	read_lanes_a: assert property (@(posedge clk) disable iff (rst)
		$fell(mem_ctl.output_enable_n) |-> mem_ctl.write_strobe_n
		&& mem_ctl.low_byte_lane_select_n == cur_ff.lane_n[0]
		&& mem_ctl.high_byte_lane_select_n == cur_ff.lane_n[1])
		else $error("read lanes mismatch");
	read_answer_a: assert property (@(posedge clk) disable iff (rst)
		$fell(mem_ctl.output_enable_n) |-> ##[3:30] rsp_valid)
		else $error("read answer missing");
endmodule : sbl_ctrl

//--- design/sbl_pkg.sv
// package for the async sram byte-lane controller
package sbl_pkg;
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned ADDR_W = 19;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned LANE_W = 8;
	// power-up wait, microseconds, as printed
	localparam int unsigned POWER_WAIT_US = 100;
	localparam int unsigned POWER_WAIT_CYC = (POWER_WAIT_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// write- and read-side timing, ns
	localparam int unsigned WRITE_PULSE_MIN_NS = 7;
	localparam int unsigned WRITE_OUTPUT_TURNOFF_TIME_NS = 5;
	localparam int unsigned WRITE_DATA_SETUP_TIME_NS = 5;
	localparam int unsigned READ_ACCESS_NS = 10;
	localparam int unsigned BUS_RELEASE_NS = 6;
	function automatic int unsigned ns_to_cyc(input int unsigned ns);
		int unsigned c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c == 0) ? 1 : c;
	endfunction : ns_to_cyc
	localparam int unsigned WR_SUM_NS = WRITE_OUTPUT_TURNOFF_TIME_NS + WRITE_DATA_SETUP_TIME_NS;
	localparam int unsigned WR_PULSE_NS = (WR_SUM_NS > WRITE_PULSE_MIN_NS) ? WR_SUM_NS
		: WRITE_PULSE_MIN_NS;
	localparam logic [3:0] WR_PULSE_CYC = 4'(ns_to_cyc(WR_PULSE_NS));
	localparam logic [3:0] RD_ACCESS_CYC = 4'(ns_to_cyc(READ_ACCESS_NS));
	localparam logic [3:0] RELEASE_CYC = 4'(ns_to_cyc(BUS_RELEASE_NS));
	localparam logic [3:0] SETUP_CYC = 4'h1;
	typedef enum logic [2:0] {
		SBL_POWER, SBL_IDLE, SBL_RD_SETUP, SBL_RD_WAIT, SBL_WR_SETUP, SBL_WR_PULSE,
		SBL_WR_HOLD, SBL_RELEASE
	} sbl_state_e;
	typedef struct packed {
		logic write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0] lane_n;
	} sbl_req_s;
	typedef struct packed {
		logic chip_select_n;
		logic output_enable_n;
		logic write_strobe_n;
		logic low_byte_lane_select_n;
		logic high_byte_lane_select_n;
	} sbl_ctl_s;
	localparam sbl_ctl_s CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
endpackage : sbl_pkg

//--- tb/sbl_sram_model.sv
// behavioural async sram on the far side of the controller
`timescale 1ns/10ps
module sbl_sram_model #(
	parameter int DLY = 10
) (
	input wire logic [18:0] addr,
	input wire sbl_pkg::sbl_ctl_s ctl,
	input wire logic [15:0] din,
	output logic [15:0] dout,
	output logic [1:0] drv
);
	logic [15:0] mem [0:524287];
	logic [15:0] q;
	logic [15:0] held = 16'h5a5a;
	wire rd = !ctl.chip_select_n && !ctl.output_enable_n && ctl.write_strobe_n;
	wire wr = !ctl.chip_select_n && !ctl.write_strobe_n;
	// strobe low or deselect drops the drive at once, ahead of any re-enable
	wire [1:0] lane_on = ~{ctl.high_byte_lane_select_n, ctl.low_byte_lane_select_n};
	assign drv = rd ? lane_on : 2'h0;
	assign q = mem[addr];
	always @* if (wr && !ctl.low_byte_lane_select_n) mem[addr][7:0] = din[7:0];
	always @* if (wr && !ctl.high_byte_lane_select_n) mem[addr][15:8] = din[15:8];
	always @* if (drv[0]) held[7:0] = q[7:0];
	always @* if (drv[1]) held[15:8] = q[15:8];
	// a released lane shows the inverse of its last value, never a stale copy
	assign #DLY dout = {drv[1] ? q[15:8] : ~held[15:8], drv[0] ? q[7:0] : ~held[7:0]};
endmodule : sbl_sram_model

//--- tb/sbl_ctrl_bench.sv
// self-checking bench for the sram byte-lane controller
`timescale 1ns/10ps
module sbl_ctrl_bench;
	logic clk = 1'b0;
	logic rst = 1'b1;
	sbl_pkg::sbl_req_s req = '0;
	logic req_valid = 1'b0;
	logic req_ready, rsp_valid, power_ready, mem_dq_oe;
	logic [15:0] rsp_rdata, mem_dq_in, mem_dq_out;
	logic [18:0] mem_addr;
	sbl_pkg::sbl_ctl_s mem_ctl;
	logic [1:0] drv;
	logic [15:0] shadow [logic [18:0]];
	logic [15:0] exp_q [$];
	logic [18:0] aq [$];
	logic [31:0] seed = 32'hf511;
	int err_total = 0;
	int n_checks = 0;
	always #50 clk = ~clk;
	sbl_ctrl dut (.clk(clk), .rst(rst), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .rsp_rdata(rsp_rdata), .rsp_valid(rsp_valid),
		.power_ready(power_ready), .mem_addr(mem_addr), .mem_ctl(mem_ctl),
		.mem_dq_in(mem_dq_in), .mem_dq_out(mem_dq_out), .mem_dq_oe(mem_dq_oe));
	sbl_sram_model #(.DLY(10)) ram (.addr(mem_addr), .ctl(mem_ctl), .din(mem_dq_out),
		.dout(mem_dq_in), .drv(drv));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
		n_checks++;
		if (s !== e)
		begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, e, s);
		end
	endtask : check
	// expectation is noted at the edge that takes the request
	task automatic op(input logic w, input logic [18:0] a, input logic [15:0] d,
		input logic [1:0] ln);
		logic [15:0] s;
		@(posedge clk);
		req <= '{w, a, d, ln};
		req_valid <= 1'b1;
		do @(negedge clk); while (req_ready !== 1'b1);
		@(posedge clk);
		req_valid <= 1'b0;
		s = shadow.exists(a) ? shadow[a] : 16'h0;
		if (w)
			shadow[a] = {ln[1] ? s[15:8] : d[15:8], ln[0] ? s[7:0] : d[7:0]};
		else
			exp_q.push_back({ln[1] ? 8'h0 : s[15:8], ln[0] ? 8'h0 : s[7:0]});
	endtask : op
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : final_report
	always @(negedge clk)
	begin
		if (rsp_valid === 1'b1)
			check("read data", exp_q.size() ? exp_q.pop_front() : 16'hdead,
				rsp_rdata);
		if (mem_dq_oe === 1'b1) check("drive clash", 16'h0, {14'h0, drv});
	end
	initial
	begin
		#(100 * 6000);
		err_total++;
		final_report();
	end
	initial
	begin
		int n;
		logic [18:0] a;
		repeat (5) @(posedge clk);
		check("reset pins", {11'h0, sbl_pkg::CTL_IDLE}, {11'h0, mem_ctl});
		rst <= 1'b0;
		n = 0;
		while (req_ready !== 1'b1)
		begin
			@(posedge clk);
			n++;
		end
		check("power wait", 16'h3, {14'h0, n >= 1000, power_ready});
		$display("test power wait done");
		op(1'b1, 19'h7ffff, 16'ha5c3, 2'b00);
		for (int l = 0; l < 3; l++) op(1'b0, 19'h7ffff, 16'h0, 2'(l));
		op(1'b1, 19'h7ffff, 16'h3c77, 2'b01);
		op(1'b1, 19'h7ffff, 16'hffff, 2'b11);
		op(1'b0, 19'h7ffff, 16'h0, 2'b00);
		$display("test byte lanes done");
		for (int i = 0; i < 24; i++)
		begin
			a = (i == 0) ? 19'h0 : 19'(xs());
			aq.push_back(a);
			op(1'b1, a, 16'(xs()), 2'b00);
		end
		foreach (aq[i]) op(1'b0, aq[i], 16'h0, 2'(xs() % 3));
		repeat (20) @(posedge clk);
		check("left over", 16'h0, 16'(exp_q.size()));
		check("idle pins", {11'h0, sbl_pkg::CTL_IDLE}, {11'h0, mem_ctl});
		$display("test random traffic done");
		final_report();
	end
endmodule : sbl_ctrl_bench
